// file: reset_cause_pkg.sv
// Constants shared by the reset-cause status block.
// Assumes an 8-bit register port with byte offsets as printed.
package reset_cause_pkg;

  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_LOW  = 8'h00;
  localparam logic [7:0] OFS_STATUS_HIGH = 8'h01;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h09;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h0a;

  // --------------------------------------------------------------
  // Low status register fields
  // --------------------------------------------------------------
  localparam int POS_POWER_ON      = 7;
  localparam int POS_RESET_PIN     = 6;
  localparam int POS_WATCHDOG      = 5;
  localparam int POS_PLL_LOCK_LOSS = 3;
  localparam int POS_EXT_CLK_LOSS  = 2;
  localparam int POS_LOW_VOLTAGE   = 1;
  localparam int POS_LOW_LEAK_EXIT = 0;

  // --------------------------------------------------------------
  // High status register fields
  // --------------------------------------------------------------
  localparam int POS_STOP_ACK_ERR  = 5;
  localparam int POS_DEBUG_PORT    = 3;
  localparam int POS_SOFTWARE      = 2;
  localparam int POS_CORE_HANG     = 1;

  // --------------------------------------------------------------
  // Load values
  // --------------------------------------------------------------
  localparam logic [7:0] LOW_POWER_ON   = 8'h82;
  localparam logic [7:0] LOW_LOW_VOLT   = 8'h02;
  localparam logic [7:0] LOW_WAKE_PIN   = 8'h41;
  localparam logic [7:0] LOW_WAKE_OTHER = 8'h01;
  localparam logic [7:0] HIGH_CLEARED   = 8'h00;
  localparam logic [7:0] IRQ_RESET_VAL  = 8'h00;

  // --------------------------------------------------------------
  // Interrupt status bits
  // --------------------------------------------------------------
  localparam int POS_IRQ_RELEASE = 0;
  localparam int POS_IRQ_FAULT   = 1;

endpackage

// file: reset_cause_status.sv
// Reset-cause status flags with a small interrupt bank.
// Assumes reset sources hold their cause levels steady while
// i_chip_reset is high; i_rstn is the power-on reset of this block.
`timescale 1ns/1ps

module reset_cause_status
  import reset_cause_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  input  wire logic                  i_clock_enable,
  input  wire logic                  i_chip_reset,
  input  wire logic                  i_power_on,
  input  wire logic                  i_reset_pin,
  input  wire logic                  i_watchdog,
  input  wire logic                  i_pll_lock_loss,
  input  wire logic                  i_ext_clock_loss,
  input  wire logic                  i_clock_monitor_enable,
  input  wire logic                  i_low_voltage_trip,
  input  wire logic                  i_low_voltage_reset_enable,
  input  wire logic                  i_wakeup,
  input  wire logic                  i_low_leak_stop,
  input  wire logic                  i_very_low_leak_stop,
  input  wire logic                  i_stop_ack_error,
  input  wire logic                  i_debug_reset_request,
  input  wire logic                  i_core_reset_request,
  input  wire logic                  i_core_hang,
  input  wire logic [ADDR_WIDTH-1:0] i_address,
  input  wire logic [7:0]            i_write_data,
  input  wire logic                  i_write_strobe,
  input  wire logic                  i_read_strobe,
  output logic      [7:0]            o_read_data,
  output logic                       o_irq
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    st_run     = 2'b01,
    st_capture = 2'b10
  } phase_t;

  phase_t      phase;
  phase_t      next_phase;
  logic [7:0]  status_low;
  logic [7:0]  status_high;
  logic [7:0]  irq_status;
  logic [7:0]  irq_enable;
  logic [7:0]  next_irq_status;
  logic [7:0]  next_irq_enable;
  logic [7:0]  next_read_data;
  logic        next_irq;

  // --------------------------------------------------------------
  // Cause qualification
  // --------------------------------------------------------------
  wire         low_volt_reset;
  wire         wake_allowed;
  wire         wake_reset;
  wire         deep_wake_reset;
  wire         clock_loss_seen;
  wire         high_cleared;
  logic [7:0]  other_low;
  logic [7:0]  other_high;
  logic [7:0]  wake_low;
  logic [7:0]  capture_low;
  logic [7:0]  capture_high;

  assign low_volt_reset  = i_low_voltage_trip & i_low_voltage_reset_enable;
  // Shallow stop only wakes through the reset pin
  assign wake_allowed    = i_very_low_leak_stop | (i_low_leak_stop & i_reset_pin);
  assign wake_reset      = i_wakeup & wake_allowed;
  assign deep_wake_reset = wake_reset & i_very_low_leak_stop;
  // A clock loss is only trusted with the monitor on
  assign clock_loss_seen = i_ext_clock_loss & i_clock_monitor_enable;
  assign high_cleared    = i_power_on | low_volt_reset | deep_wake_reset;

  always_comb begin
    other_low                    = 8'h00;
    other_low[POS_RESET_PIN]     = i_reset_pin;
    other_low[POS_WATCHDOG]      = i_watchdog;
    other_low[POS_PLL_LOCK_LOSS] = i_pll_lock_loss;
    other_low[POS_EXT_CLK_LOSS]  = clock_loss_seen;
    other_low[POS_LOW_LEAK_EXIT] = 1'b0;
  end

  always_comb begin
    other_high                   = 8'h00;
    other_high[POS_STOP_ACK_ERR] = i_stop_ack_error;
    other_high[POS_DEBUG_PORT]   = i_debug_reset_request;
    other_high[POS_SOFTWARE]     = i_core_reset_request;
    other_high[POS_CORE_HANG]    = i_core_hang;
  end

  assign wake_low = i_reset_pin ? LOW_WAKE_PIN : LOW_WAKE_OTHER;

  // Power-on outranks low voltage, which outranks a wakeup
  assign capture_low = i_power_on     ? LOW_POWER_ON :
                       low_volt_reset ? LOW_LOW_VOLT :
                       wake_reset     ? wake_low     :
                       other_low;
  assign capture_high = high_cleared ? HIGH_CLEARED : other_high;

  // --------------------------------------------------------------
  // Capture phase
  // --------------------------------------------------------------
  wire         capturing;
  wire         released;

  assign capturing = i_chip_reset;
  assign released  = (phase == st_capture) & ~i_chip_reset;

  always_comb begin
    case (phase)
      st_run:     next_phase = i_chip_reset ? st_capture : st_run;
      st_capture: next_phase = i_chip_reset ? st_capture : st_run;
      default:    next_phase = st_run;
    endcase
  end

  // --------------------------------------------------------------
  // Register port decode
  // --------------------------------------------------------------
  wire         sel_low;
  wire         sel_high;
  wire         sel_irq_status;
  wire         sel_irq_clear;
  wire         sel_irq_enable;
  wire         clear_write;
  wire         enable_write;
  logic [7:0]  read_mux;

  assign sel_low        = i_address == ADDR_WIDTH'(OFS_STATUS_LOW);
  assign sel_high       = i_address == ADDR_WIDTH'(OFS_STATUS_HIGH);
  assign sel_irq_status = i_address == ADDR_WIDTH'(OFS_IRQ_STATUS);
  assign sel_irq_clear  = i_address == ADDR_WIDTH'(OFS_IRQ_CLEAR);
  assign sel_irq_enable = i_address == ADDR_WIDTH'(OFS_IRQ_ENABLE);
  // Status flags have no write path at all
  assign clear_write    = i_write_strobe & sel_irq_clear;
  assign enable_write   = i_write_strobe & sel_irq_enable;

  // Clear register reads back zero, like unmapped space
  assign read_mux = sel_low        ? status_low  :
                    sel_high       ? status_high :
                    sel_irq_status ? irq_status  :
                    sel_irq_enable ? irq_enable  :
                    8'h00;
  assign next_read_data = i_read_strobe ? read_mux : 8'h00;

  // --------------------------------------------------------------
  // Interrupt bank
  // --------------------------------------------------------------
  wire         fault_cause;
  logic [7:0]  irq_set;
  logic [7:0]  irq_clear;

  // Judged on the values frozen at release
  assign fault_cause = (|status_high)
                     | status_low[POS_WATCHDOG]
                     | status_low[POS_PLL_LOCK_LOSS]
                     | status_low[POS_EXT_CLK_LOSS];

  always_comb begin
    irq_set                  = 8'h00;
    irq_set[POS_IRQ_RELEASE] = released;
    irq_set[POS_IRQ_FAULT]   = released & fault_cause;
  end

  assign irq_clear = clear_write ? i_write_data : 8'h00;
  // Sticky register only moves on a set or a clear
  wire         irq_touch;
  assign irq_touch = clear_write | (|irq_set);
  // Set wins so a release during a clear is not lost
  assign next_irq_status = (irq_status & ~irq_clear) | irq_set;
  assign next_irq_enable = enable_write ? i_write_data : irq_enable;
  assign next_irq        = |(next_irq_status & next_irq_enable);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Reload every cycle of reset; frozen from release onward
  hold_reg #(
    .WIDTH       (8),
    .RESET_VALUE (LOW_POWER_ON)
  ) low_reg_u (
    .i_clock        (i_clock),
    .i_rstn         (i_rstn),
    .i_clock_enable (i_clock_enable),
    .i_load         (capturing),
    .i_value        (capture_low),
    .o_value        (status_low)
  );

  // Reserved bits are zero in every capture value, so none can latch
  hold_reg #(
    .WIDTH       (8),
    .RESET_VALUE (HIGH_CLEARED)
  ) high_reg_u (
    .i_clock        (i_clock),
    .i_rstn         (i_rstn),
    .i_clock_enable (i_clock_enable),
    .i_load         (capturing),
    .i_value        (capture_high),
    .o_value        (status_high)
  );

  // Sticky interrupt flags
  hold_reg #(
    .WIDTH       (8),
    .RESET_VALUE (IRQ_RESET_VAL)
  ) irq_status_u (
    .i_clock        (i_clock),
    .i_rstn         (i_rstn),
    .i_clock_enable (i_clock_enable),
    .i_load         (irq_touch),
    .i_value        (next_irq_status),
    .o_value        (irq_status)
  );

  // Only a write to its own offset loads the enable
  hold_reg #(
    .WIDTH       (8),
    .RESET_VALUE (IRQ_RESET_VAL)
  ) irq_enable_u (
    .i_clock        (i_clock),
    .i_rstn         (i_rstn),
    .i_clock_enable (i_clock_enable),
    .i_load         (enable_write),
    .i_value        (i_write_data),
    .o_value        (irq_enable)
  );

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      phase <= st_run;
    end else if (i_clock_enable) begin
      phase <= next_phase;
    end
  end

  // --------------------------------------------------------------
  // Output flops
  // --------------------------------------------------------------
  // Both outputs freeze with the enable, like every other flop
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else if (i_clock_enable) begin
      o_irq <= next_irq;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_read_data <= 8'h00;
    end else if (i_clock_enable) begin
      o_read_data <= next_read_data;
    end
  end

endmodule

// --------------------------------------------------------------
// Loadable register with a fixed reset value
// --------------------------------------------------------------
module hold_reg #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_clock_enable,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_value,
  output logic      [WIDTH-1:0] o_value
);

  // Load is qualified by the enable so a frozen clock holds every bit
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_value <= RESET_VALUE;
    end else if (i_clock_enable && i_load) begin
      o_value <= i_value;
    end
  end

endmodule

// file: reset_cause_chk.sv
// Port assertions for the reset-cause status block.
// Bound to reset_cause_status; sees its ports only.
`timescale 1ns/1ps
module reset_cause_chk #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  i_clock,
  input wire logic                  i_rstn,
  input wire logic                  i_clock_enable,
  input wire logic                  i_chip_reset,
  input wire logic                  i_power_on,
  input wire logic [ADDR_WIDTH-1:0] i_address,
  input wire logic [7:0]            i_write_data,
  input wire logic                  i_write_strobe,
  input wire logic                  i_read_strobe,
  input wire logic [7:0]            o_read_data,
  input wire logic                  o_irq
);
  logic fresh;
  wire  rd = i_clock_enable && i_read_strobe;
  // ---------------------------------------------
  // No chip reset since power-on
  // ---------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn)
    if (!i_rstn) fresh <= 1'b1;
    else if (i_chip_reset && i_clock_enable) fresh <= 1'b0;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  read_idle_zero_a: assert property (i_clock_enable && !i_read_strobe |=> o_read_data == 8'h00)
    else $error("read data not cleared");
  high_reserved_a: assert property (rd && i_address == 'h1 |=> (o_read_data & 8'hd1) == 8'h00)
    else $error("reserved high bit set");
  por_low_a: assert property (fresh && rd && i_address == 'h0 |=> o_read_data == 8'h82)
    else $error("low status not 82 after power-on");
  por_high_a: assert property (fresh && rd && i_address == 'h1 |=> o_read_data == 8'h00)
    else $error("high status not 00 after power-on");
  capture_por_a: assert property (rd && i_address < 2 && $past(i_chip_reset && i_power_on && i_clock_enable)
    |=> o_read_data == ($past(i_address[0]) ? 8'h00 : 8'h82))
    else $error("power-on capture wrong");
  unmapped_zero_a: assert property (rd && i_address > 1 && i_address < 8 |=> o_read_data == 8'h00)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (i_clock_enable && i_write_strobe && i_address == 'h0a && i_write_data == 8'h00
    |=> !o_irq)
    else $error("irq high while disabled");
  reset_quiet_a: assert property ($rose(i_rstn) |-> !o_irq && o_read_data == 8'h00)
    else $error("outputs not quiet after reset");
  cover property (fresh && rd);
  cover property ($rose(o_irq));
  cover property (i_chip_reset && i_power_on);
  cover property (!i_clock_enable && i_chip_reset);
  frozen_output_a: assert property (!i_clock_enable |=> $stable(o_read_data) && $stable(o_irq))
    else $error("outputs moved while enable low");
endmodule

// file: reset_source_model.sv
// Far side: chip reset sources feeding the reset-cause block.
// Assumes a one-cycle start pulse from the bench.
`timescale 1ns/1ps
module reset_source_model (
  input  wire logic        i_clock,
  input  wire logic        i_start,
  input  wire logic [14:0] i_cause,
  output logic             o_chip_reset,
  output logic [14:0]      o_cause
);
  logic [1:0]  left = 2'd0;
  logic [14:0] noise = '0;
  // Causes mean nothing outside reset, so churn them there
  always @(posedge i_clock) begin
    noise <= 15'($urandom);
    if (i_start) left <= 2'd2;
    else if (left != 2'd0) left <= left - 2'd1;
  end
  assign o_chip_reset = left != 2'd0;
  assign o_cause      = o_chip_reset ? i_cause : noise;
endmodule

// file: testbench.sv
// Self-checking bench for the reset-cause status block.
// Causes come through the reset source model; checker bound below.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  logic        i_clock = 0;
  logic        i_rstn = 0;
  logic        start = 0;
  logic        clock_enable = 1'b1;
  logic        i_write_strobe = 0;
  logic        i_read_strobe = 0;
  logic        chip_reset, o_irq;
  logic [7:0]  i_address = '0;
  logic [7:0]  i_write_data = '0;
  logic [7:0]  o_read_data, d;
  logic [14:0] cause = '0;
  logic [14:0] src, c;
  logic [15:0] e;
  int          fail_count = 0;
  int          cmp_count = 0;
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  reset_source_model src_u (.i_clock(i_clock), .i_start(start), .i_cause(cause), .o_chip_reset(chip_reset),
    .o_cause(src));
  reset_cause_status dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_clock_enable(clock_enable),
    .i_chip_reset(chip_reset),
    .i_power_on(src[0]), .i_reset_pin(src[1]), .i_watchdog(src[2]), .i_pll_lock_loss(src[3]),
    .i_ext_clock_loss(src[4]), .i_clock_monitor_enable(src[5]), .i_low_voltage_trip(src[6]),
    .i_low_voltage_reset_enable(src[7]), .i_wakeup(src[8]), .i_low_leak_stop(src[9]),
    .i_very_low_leak_stop(src[10]), .i_stop_ack_error(src[11]), .i_debug_reset_request(src[12]),
    .i_core_reset_request(src[13]), .i_core_hang(src[14]), .i_address(i_address), .i_write_data(i_write_data),
    .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe), .o_read_data(o_read_data), .o_irq(o_irq));
  // ---------------------------------------------
  // Bus and reference model
  // ---------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_address <= a;
    i_write_data <= v;
    i_write_strobe <= 1'b1;
    @(posedge i_clock);
    i_write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_address <= a;
    i_read_strobe <= 1'b1;
    @(posedge i_clock);
    i_read_strobe <= 1'b0;
    @(negedge i_clock);
    d = o_read_data;
  endtask
  task automatic run(input logic [14:0] v);
    @(posedge i_clock);
    cause <= v;
    start <= 1'b1;
    @(posedge i_clock);
    start <= 1'b0;
  endtask
  function automatic logic [15:0] exp_of(input logic [14:0] v);
    logic [7:0] lo, hi;
    hi = {2'b0, v[11], 1'b0, v[12], v[13], v[14], 1'b0};
    lo = {1'b0, v[1], v[2], 1'b0, v[3], v[4] & v[5], 2'b0};
    if (v[0]) {hi, lo} = 16'h0082;
    else if (v[6] & v[7]) {hi, lo} = 16'h0002;
    else if (v[8] & (v[10] | (v[9] & v[1]))) begin
      lo = v[1] ? 8'h41 : 8'h01;
      if (v[10]) hi = 8'h00;
    end
    return {hi, lo};
  endfunction
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(2));
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(8'h00);
    `CHK("status_low", 8'h82, d)
    rd(8'h01);
    `CHK("status_high", 8'h00, d)
    rd(8'h05);
    `CHK("unmapped", 8'h00, d)
    $display("power-on test done");
    wr(8'h0a, 8'h01);
    for (int i = 0; i < 60; i++) begin
      c = i < 15 ? 15'h00a0 | (15'h1 << i) : 15'($urandom) & 15'h7ffe;
      e = exp_of(c);
      run(c);
      rd(8'h00);
      `CHK("status_low", e[7:0], d)
      rd(8'h01);
      `CHK("status_high", e[15:8], d)
      wr(8'h00, 8'($urandom));
      wr(8'h01, 8'hff);
      rd(8'h00);
      `CHK("held_low", e[7:0], d)
      rd(8'h01);
      `CHK("held_high", e[15:8], d)
      $display("test %0d done", i);
    end
    `CHK("irq", 1'b1, o_irq)
    wr(8'h09, 8'hff);
    rd(8'h08);
    `CHK("irq_status", 8'h00, d)
    `CHK("irq", 1'b0, o_irq)
    wr(8'h0a, 8'h00);
    run(15'h0004);
    repeat (4) @(negedge i_clock);
    `CHK("irq_masked", 1'b0, o_irq)
    rd(8'h08);
    `CHK("irq_status", 8'h03, d)
    wr(8'h0a, 8'h03);
    repeat (2) @(negedge i_clock);
    `CHK("irq", 1'b1, o_irq)
    $display("irq test done");
    // Enable low across a chip reset: flags and irq must not move
    @(posedge i_clock);
    clock_enable <= 1'b0;
    run(15'h00a8);
    repeat (4) @(posedge i_clock);
    clock_enable <= 1'b1;
    e = exp_of(15'h0004);
    rd(8'h00);
    `CHK("frozen_low", e[7:0], d)
    rd(8'h08);
    `CHK("frozen_irq", 8'h03, d)
    `CHK("frozen_irq_out", 1'b1, o_irq)
    // Second power-on in mid-run
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(8'h00);
    `CHK("status_low", 8'h82, d)
    rd(8'h01);
    `CHK("status_high", 8'h00, d)
    rd(8'h08);
    `CHK("irq_status", 8'h00, d)
    `CHK("irq", 1'b0, o_irq)
    $display("freeze and reset test done");
    wrap_up();
  end
endmodule
bind reset_cause_status reset_cause_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_clock_enable(i_clock_enable), .i_chip_reset(i_chip_reset), .i_power_on(i_power_on), .i_address(i_address),
  .i_write_data(i_write_data), .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe),
  .o_read_data(o_read_data), .o_irq(o_irq));
